// >>> dv/testbench.sv
// Self-checking bench for the match-B and wrap status block
`include "timer_grb_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus, model state and result queues
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic standby = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] cnt [3];
  logic [15:0] grb [3];
  timer_grb_pkg::chan_vec_t cap_mode = 3'h0;
  timer_grb_pkg::chan_vec_t cap_strobe = 3'h0;
  logic phase_sel = 1'b0;
  logic flag_dir = 1'b0;
  logic [5:0] irq;
  logic [31:0] rnd;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h0000_73f4;
  logic [2:0] en_m [2] = '{3'h0, 3'h0};
  logic [2:0] fl_m [2] = '{3'h0, 3'h0};
  logic [2:0] arm_m [2] = '{3'h0, 3'h0};
  logic [31:0] rd_q [$];
  logic [5:0] irq_q [$];

  always #20 clk = ~clk;

  timer_grb_overflow_irq_status i_dut (
    .clk(clk), .reset_n(reset_n), .standby(standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_reg_ch0(cnt[0]), .count_reg_ch1(cnt[1]), .count_reg_ch2(cnt[2]),
    .general_reg_b_ch0(grb[0]), .general_reg_b_ch1(grb[1]), .general_reg_b_ch2(grb[2]),
    .grb_capture_mode(cap_mode), .grb_capture_strobe(cap_strobe),
    .phase_count_select(phase_sel), .wrap_flag_direction(flag_dir),
    .match_b_irq_ch0(irq[0]), .match_b_irq_ch1(irq[1]), .match_b_irq_ch2(irq[2]),
    .wrap_irq_ch0(irq[3]), .wrap_irq_ch1(irq[4]), .wrap_irq_ch2(irq[5])
  );

  // ----------------------------------------------------------------
  // Compare tasks, monitor and closing
  // ----------------------------------------------------------------
  task automatic cmp_rd(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_irq(logic [5:0] got, logic [5:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected requests at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data taken at the completing edge; it has stood there since the latching edge
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) cmp_rd(avs_readdata, rd_q.pop_front());
  end

  // Falling edge sampling keeps the request compare clear of the edge that updates flags and enables
  always @(negedge clk) begin
    if (irq_q.size() > 0) cmp_irq(irq, irq_q.pop_front());
  end

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole sequence needs about 300 cycles; the 5000-cycle limit allows many times that
  initial begin
    #200000;
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Bus, event and model tasks
  // ----------------------------------------------------------------
  // Request held until waitrequest is seen low; inj makes a ch0 match land on the completing edge
  task automatic bus(logic wr, logic [2:0] addr, logic [7:0] data, logic [3:0] be, logic inj);
    logic w;
    int n;
    w = 1'b1;
    n = 0;
    @(posedge clk);
    avs_address <= addr;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, data};
    avs_byteenable <= be;
    while (w !== 1'b0 && n < 50) begin
      @(posedge clk);
      if (inj && n == 0) cnt[0] <= grb[0];
      w = avs_waitrequest;
      n++;
    end
    if (w !== 1'b0) err_total++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(int i);
    rd_q.push_back({24'h00_0000, 1'b1, en_m[i], 1'b1, fl_m[i]});
    arm_m[i] = fl_m[i];
    bus(1'b0, i ? `WRAP_OFFSET : `MATCH_B_OFFSET, 8'h00, 4'h1, 1'b0);
  endtask

  // Only flags armed by an earlier read take a written zero
  task automatic wr(int i, logic [7:0] d, logic inj);
    bus(1'b1, i ? `WRAP_OFFSET : `MATCH_B_OFFSET, d, 4'h1, inj);
    en_m[i] = d[6:4];
    fl_m[i] = fl_m[i] & (d[2:0] | ~arm_m[i]);
    arm_m[i] = 3'h0;
  endtask

  task automatic chk_irq();
    irq_q.push_back({fl_m[1] & en_m[1], fl_m[0] & en_m[0]});
    @(posedge clk);
  endtask

  // Random counts never hit 0x0000, 0xFFFF or a register B value (bit 15 differs)
  task automatic scramble();
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      cnt[i] <= {1'b0, rnd[14:1], 1'b1};
    end
    @(posedge clk);
  endtask

  // Kind 0 compare, 1 capture, 2 upward wrap, 3 downward wrap
  task automatic ev(int kind, int ch, logic hit);
    @(posedge clk);
    case (kind)
      0: cnt[ch] <= grb[ch];
      1: cap_strobe[ch] <= 1'b1;
      default: cnt[ch] <= (kind == 2) ? 16'hffff : 16'h0000;
    endcase
    @(posedge clk);
    cap_strobe <= 3'h0;
    if (kind >= 2) cnt[ch] <= (kind == 2) ? 16'h0000 : 16'hffff;
    @(posedge clk);
    if (hit) fl_m[kind >= 2][ch] = 1'b1;
    scramble();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      cnt[i] = 16'h0001;
      grb[i] = {2'b10, rnd[13:0]};
    end
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(0);
    rd(1);
    rd_q.push_back(32'h0000_0000);
    bus(1'b0, 3'h2, 8'h00, 4'h1, 1'b0);
    bus(1'b1, `MATCH_B_OFFSET, 8'hff, 4'h0, 1'b0);
    rd(0);
    wr(0, 8'hff, 1'b0);
    wr(1, 8'hff, 1'b0);
    rd(0);
    rd(1);
    // Compare, capture and upward wrap on every channel, then masking and clearing
    for (int ch = 0; ch < 3; ch++) begin
      for (int k = 0; k < 3; k++) begin
        cap_mode[ch] <= (k == 1);
        ev(k, ch, 1'b1);
        wr(k == 2, 8'h07, 1'b0);
        chk_irq();
        wr(k == 2, 8'h70, 1'b0);
        chk_irq();
        rd(k == 2);
        wr(k == 2, 8'h70, 1'b0);
        chk_irq();
      end
    end
    // Downward wrap only with phase counting and direction zero
    for (int m = 0; m < 3; m++) begin
      phase_sel <= (m != 1);
      flag_dir <= (m == 2);
      ev(3, 2, m == 0);
      rd(1);
      wr(1, 8'h70, 1'b0);
    end
    ev(2, 2, 1'b1);
    ev(3, 0, 1'b0);
    ev(3, 1, 1'b0);
    rd(1);
    // Clearing write meets a new match on the same edge
    ev(0, 0, 1'b1);
    rd(0);
    wr(0, 8'h70, 1'b1);
    fl_m[0][0] = 1'b1;
    rd(0);
    chk_irq();
    // Standby returns both registers to their reset state
    @(posedge clk);
    standby <= 1'b1;
    // Counters also return to zero in standby, so no stale match appears once it ends
    for (int i = 0; i < 3; i++) cnt[i] <= 16'h0000;
    @(posedge clk);
    standby <= 1'b0;
    en_m = '{3'h0, 3'h0};
    fl_m = '{3'h0, 3'h0};
    rd(0);
    rd(1);
    chk_irq();
    conclude();
  end
endmodule

// >>> hw/flag_cell.sv
// One status flag with read-then-write-zero clearing
module flag_cell (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic standby,
  input wire logic set_evt,
  input wire logic read_hit,
  input wire logic write_hit,
  input wire logic write_bit,
  output logic flag_q
);

  logic armed_q;

  // ----------------------------------------------------------------
  // Arm: a read that sees the flag high permits the next clear
  // ----------------------------------------------------------------
  // Any later write to the register's low byte uses up the arm, so a stale read cannot clear a new event
  always_ff @(posedge clk) begin
    if (!reset_n || standby) begin
      armed_q <= 1'b0;
    end else if (read_hit && flag_q) begin
      armed_q <= 1'b1;
    end else if (write_hit) begin
      armed_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flag: set wins over a clearing write in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || standby) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (write_hit && !write_bit && armed_q) begin
      flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_clear_needs_arm: assert property (
    ($fell(flag_q) && !$past(standby)) |-> $past(armed_q && write_hit && !write_bit))
    else $error("flag cleared without a prior read of one");

  a_set_beats_clear: assert property (
    (set_evt && !standby) |=> flag_q)
    else $error("flag lost a set event");

  a_write_one_keeps: assert property (
    (write_hit && write_bit && !standby && !set_evt) |=> (flag_q == $past(flag_q)))
    else $error("writing one changed a flag");

endmodule

// >>> hw/timer_grb_defs.svh
// Offsets, field positions, reset values and wrap limits of the match-B and wrap status block
`ifndef TIMER_GRB_DEFS_SVH
`define TIMER_GRB_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses on the Avalon slave
// ----------------------------------------------------------------
`define MATCH_B_OFFSET 3'h0
`define WRAP_OFFSET 3'h4

// ----------------------------------------------------------------
// Field positions inside each 8-bit register
// ----------------------------------------------------------------
`define FLAG_LSB 0
`define ENABLE_LSB 4
`define FIXED_HI_BIT 7
`define FIXED_LO_BIT 3

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define STATUS_RESET 8'h88
`define ENABLE_RESET 3'h0
`define COUNT_TOP 16'hffff
`define COUNT_BOTTOM 16'h0000

`endif

// >>> hw/timer_grb_overflow_irq_status.sv
// Match-B and counter wrap status, enables and interrupt requests of a three-channel timer
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`include "timer_grb_defs.svh"

// Function
// - The match-B status register is eight bits that become 0x88 at reset and on standby.
// - The wrap status register is eight bits that become 0x88 at reset and on standby.
// - Bits 7 and 3 of both registers always read one and ignore writes.
// - A flag bit only takes a written zero, which clears it; a written one leaves it alone.
// - A flag clears only when the zero write follows a read that saw the flag at one.
// - In compare mode a channel's match-B flag sets when its counter steps onto the value of general register B.
// - In capture mode a channel's match-B flag sets when the counter is captured into register B.
// - Bits 6 to 4 of the match-B register enable the match-B requests of channels 2 to 0.
// - Bits 6 to 4 of the wrap register enable the wrap requests of channels 2 to 0.
// - Channel 2 wrap flag sets on a wrap from 0xFFFF to 0x0000 or from 0x0000 to 0xFFFF.
// - Only channel 2 wraps downward, and only in phase counting mode.
// - Channels 1 and 0 wrap flags set only on an upward wrap from 0xFFFF to 0x0000.
// - With flag direction zero both wrap directions set the channel 2 flag, with one only upward.
module timer_grb_overflow_irq_status (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic standby,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] count_reg_ch0,
  input wire logic [15:0] count_reg_ch1,
  input wire logic [15:0] count_reg_ch2,
  input wire logic [15:0] general_reg_b_ch0,
  input wire logic [15:0] general_reg_b_ch1,
  input wire logic [15:0] general_reg_b_ch2,
  input wire logic [2:0] grb_capture_mode,
  input wire logic [2:0] grb_capture_strobe,
  input wire logic phase_count_select,
  input wire logic wrap_flag_direction,
  output logic match_b_irq_ch0,
  output logic match_b_irq_ch1,
  output logic match_b_irq_ch2,
  output logic wrap_irq_ch0,
  output logic wrap_irq_ch1,
  output logic wrap_irq_ch2
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  timer_grb_pkg::acc_phase_t phase_q;
  logic [31:0] readdata_q;
  logic [15:0] count_w [3];
  logic [15:0] grb_w [3];
  logic [15:0] count_prev_q [3];
  timer_grb_pkg::chan_vec_t match_set;
  timer_grb_pkg::chan_vec_t up_wrap;
  timer_grb_pkg::chan_vec_t down_wrap;
  timer_grb_pkg::chan_vec_t wrap_set;
  timer_grb_pkg::chan_vec_t match_en_q;
  timer_grb_pkg::chan_vec_t wrap_en_q;
  timer_grb_pkg::chan_vec_t match_flag;
  timer_grb_pkg::chan_vec_t wrap_flag;
  logic [5:0] set_all;
  logic [5:0] flag_all;
  logic [7:0] match_reg_val;
  logic [7:0] wrap_reg_val;
  logic [7:0] read_mux;
  logic access_done;
  logic sel_match;
  logic sel_wrap;
  logic read_match;
  logic read_wrap;
  logic write_match;
  logic write_wrap;
  logic low_lane;
  logic ch2_down_allowed;

  // ----------------------------------------------------------------
  // Channel buses gathered into arrays for the per-channel loop
  // ----------------------------------------------------------------
  assign count_w[0] = count_reg_ch0;
  assign count_w[1] = count_reg_ch1;
  assign count_w[2] = count_reg_ch2;
  assign grb_w[0] = general_reg_b_ch0;
  assign grb_w[1] = general_reg_b_ch1;
  assign grb_w[2] = general_reg_b_ch2;

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  // The fixed wait state lets read data come from a flip-flop without a readdatavalid path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_q <= timer_grb_pkg::ACC_IDLE;
    end else begin
      unique case (phase_q)
        timer_grb_pkg::ACC_IDLE: begin
          if (avs_read || avs_write) begin
            phase_q <= timer_grb_pkg::ACC_ANSWER;
          end
        end
        timer_grb_pkg::ACC_ANSWER: begin
          phase_q <= timer_grb_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Request stalls in the idle phase and completes in the answer phase
  assign avs_waitrequest = (avs_read || avs_write) && (phase_q == timer_grb_pkg::ACC_IDLE);
  assign access_done = (phase_q == timer_grb_pkg::ACC_ANSWER);

  // Address decode; other addresses read as zero and drop writes
  assign sel_match = (avs_address == `MATCH_B_OFFSET);
  assign sel_wrap = (avs_address == `WRAP_OFFSET);
  assign low_lane = avs_byteenable[0];
  // Arm on the edge that latches read data, so that only a one the reader really saw can arm a clear
  // A flag set between latch and completion reads as zero and must stay unarmed
  assign read_match = !access_done && avs_read && sel_match;
  assign read_wrap = !access_done && avs_read && sel_wrap;
  assign write_match = access_done && avs_write && sel_match && low_lane;
  assign write_wrap = access_done && avs_write && sel_wrap && low_lane;

  // ----------------------------------------------------------------
  // Register views: fixed ones, enables and flags
  // ----------------------------------------------------------------
  assign match_reg_val = {1'b1, match_en_q, 1'b1, match_flag};
  assign wrap_reg_val = {1'b1, wrap_en_q, 1'b1, wrap_flag};

  // Read multiplexer, sampled into the data register while the bus waits
  always_comb begin
    read_mux = 8'h00;
    if (sel_match) begin
      read_mux = match_reg_val;
    end else if (sel_wrap) begin
      read_mux = wrap_reg_val;
    end
  end

  // Read data stands from the answer cycle until the next read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read && phase_q == timer_grb_pkg::ACC_IDLE) begin
      readdata_q <= {24'h00_0000, read_mux};
    end
  end

  assign avs_readdata = readdata_q;

  // ----------------------------------------------------------------
  // Interrupt enable fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || standby) begin
      match_en_q <= `ENABLE_RESET;
    end else if (write_match) begin
      match_en_q <= avs_writedata[`ENABLE_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || standby) begin
      wrap_en_q <= `ENABLE_RESET;
    end else if (write_wrap) begin
      wrap_en_q <= avs_writedata[`ENABLE_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Event detection per channel
  // ----------------------------------------------------------------
  // Downward wraps count only on channel 2 in phase counting with direction zero
  assign ch2_down_allowed = phase_count_select && !wrap_flag_direction;

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_chan
      // Previous counter value, used to see a wrap and a fresh match
      always_ff @(posedge clk) begin
        if (!reset_n || standby) begin
          count_prev_q[c] <= `COUNT_BOTTOM;
        end else begin
          count_prev_q[c] <= count_w[c];
        end
      end

      // Compare match fires once as the counter steps onto the register value
      assign match_set[c] = grb_capture_mode[c] ? grb_capture_strobe[c]
                            : (count_w[c] == grb_w[c]) && (count_w[c] != count_prev_q[c]);

      assign up_wrap[c] = (count_prev_q[c] == `COUNT_TOP) && (count_w[c] == `COUNT_BOTTOM);
      assign down_wrap[c] = (count_prev_q[c] == `COUNT_BOTTOM) && (count_w[c] == `COUNT_TOP);

      if (c == 2) begin : g_updown
        assign wrap_set[c] = up_wrap[c] || (down_wrap[c] && ch2_down_allowed);
      end else begin : g_up
        assign wrap_set[c] = up_wrap[c];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Status flags: three match-B then three wrap cells
  // ----------------------------------------------------------------
  assign set_all = {wrap_set, match_set};
  assign match_flag = flag_all[2:0];
  assign wrap_flag = flag_all[5:3];

  genvar f;
  generate
    for (f = 0; f < 6; f++) begin : g_flag
      flag_cell u_flag (
        .clk(clk),
        .reset_n(reset_n),
        .standby(standby),
        .set_evt(set_all[f]),
        .read_hit((f < 3) ? read_match : read_wrap),
        .write_hit((f < 3) ? write_match : write_wrap),
        .write_bit(avs_writedata[`FLAG_LSB + (f % 3)]),
        .flag_q(flag_all[f])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt requests: flag gated by enable
  // ----------------------------------------------------------------
  // Level requests; they fall as soon as software clears the flag or the enable
  assign match_b_irq_ch0 = match_flag[0] && match_en_q[0];
  assign match_b_irq_ch1 = match_flag[1] && match_en_q[1];
  assign match_b_irq_ch2 = match_flag[2] && match_en_q[2];
  assign wrap_irq_ch0 = wrap_flag[0] && wrap_en_q[0];
  assign wrap_irq_ch1 = wrap_flag[1] && wrap_en_q[1];
  assign wrap_irq_ch2 = wrap_flag[2] && wrap_en_q[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_match_reset_value: assert property (
    ($past(!reset_n) || $past(standby)) |-> (match_reg_val == `STATUS_RESET))
    else $error("match-B register not 0x88 after reset or standby");

  a_wrap_reset_value: assert property (
    ($past(!reset_n) || $past(standby)) |-> (wrap_reg_val == `STATUS_RESET))
    else $error("wrap register not 0x88 after reset or standby");

  a_fixed_ones_read: assert property (
    (avs_read && !avs_waitrequest && (sel_match || sel_wrap))
      |-> (avs_readdata[`FIXED_HI_BIT] && avs_readdata[`FIXED_LO_BIT]))
    else $error("fixed bits did not read as one");

  a_match_sets_flag: assert property (
    (!grb_capture_mode[1] && count_reg_ch1 == general_reg_b_ch1 && count_reg_ch1 != $past(count_reg_ch1)
      && !standby) |=> match_flag[1])
    else $error("compare match did not set the channel 1 flag");

  a_capture_sets_flag: assert property (
    (grb_capture_mode[0] && grb_capture_strobe[0] && !standby) |=> match_flag[0])
    else $error("capture did not set the channel 0 flag");

  a_up_wrap_sets: assert property (
    ($past(count_reg_ch0) == `COUNT_TOP && count_reg_ch0 == `COUNT_BOTTOM && !standby) |=> wrap_flag[0])
    else $error("channel 0 overflow did not set its flag");

  a_down_wrap_gate: assert property (
    (!$past(wrap_flag[2]) && wrap_flag[2]) |-> $past(up_wrap[2] || (down_wrap[2] && phase_count_select)))
    else $error("channel 2 wrap flag set without a legal wrap");

  a_direction_gate: assert property (
    (wrap_flag_direction && down_wrap[2] && !up_wrap[2] && !wrap_flag[2]) |=> !wrap_flag[2])
    else $error("underflow set the flag with direction one");

  a_ch2_down_sets: assert property (
    (down_wrap[2] && ch2_down_allowed && !standby) |=> wrap_flag[2])
    else $error("allowed underflow did not set the channel 2 flag");

  a_enable_write: assert property (
    (write_match && !standby) |=> (match_en_q == $past(avs_writedata[`ENABLE_LSB +: 3])))
    else $error("match-B enable did not take the written value");

  a_irq_falls_clear: assert property (
    ($fell(wrap_flag[1]) || $fell(wrap_en_q[1])) |-> !wrap_irq_ch1)
    else $error("wrap request stayed up after flag or enable cleared");

  a_irq_needs_enable: assert property (
    wrap_irq_ch2 |-> ($past(write_wrap && avs_writedata[`ENABLE_LSB + 2]) || $past(wrap_en_q[2])))
    else $error("wrap request without its enable written");

  a_ch1_up_only: assert property (
    (down_wrap[1] && !wrap_flag[1]) |=> !wrap_flag[1])
    else $error("channel 1 flag set by a downward wrap");

  a_ch2_phase_gate: assert property (
    (down_wrap[2] && !phase_count_select && !wrap_flag[2]) |=> !wrap_flag[2])
    else $error("channel 2 flag set by a downward wrap outside phase counting");

  a_wrap_enable_write: assert property (
    (write_wrap && !standby) |=> (wrap_en_q == $past(avs_writedata[`ENABLE_LSB +: 3])))
    else $error("wrap enable did not take the written value");

endmodule

// >>> hw/timer_grb_pkg.sv
// Types shared by the match-B and wrap status block
package timer_grb_pkg;

  // ----------------------------------------------------------------
  // Bus access phase, Gray coded along request then answer
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_ANSWER = 1'b1
  } acc_phase_t;

  // One bit per timer channel
  typedef logic [2:0] chan_vec_t;

endpackage
